// ==== design/accel_filter_pkg.sv ====
// shared constants, types and decode for the filter path and status bank
//
// Operation
// [R1] clock select bit picks internal or external clock
// [R2] external clock 1.045 MHz, 10 percent, 50 duty
// [R3] control register field layout, fields reset zero
// [R4] direction logic fed raw or filtered data
// [R5] free-fall logic fed raw or filtered data
// [R6] output registers fed raw or filtered data
// [R7] cut-off field selects coefficient 512 to 4096
// [R8] cut-off equals 0.318 over coefficient, half rate
// [R9] generator results load both source registers
// [R10] identification register returns fixed code
// [R11] status register flag layout, all reset zero
// [R12] set overrun when unread set overwritten
// [R13] axis overrun when unread sample overwritten
// [R14] axis available set on new sample
// [R15] set available on all enabled, cleared after reads
// [R16] set overrun cleared after all high reads
// [R17] axis available cleared by high byte read
// [R18] axis overrun cleared by high byte read
// [R19] software rewrites reserved bits with default
// [R20] writes to status and identification ignored
package accel_filter_pkg;

    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam logic [6:0] ADDR_ID_CODE              = 7'h0f;
    localparam logic [6:0] ADDR_FILTER_CLOCK_CONTROL = 7'h22;
    localparam logic [6:0] ADDR_SAMPLE_STATUS        = 7'h27;

    // reserved pair of the control register and reset values
    localparam logic [1:0] RESERVED_DEFAULT = 2'h2;
    localparam logic [7:0] CONTROL_RESET    = 8'h08;
    localparam logic [7:0] STATUS_RESET     = 8'h00;
    localparam logic [7:0] UNMAPPED_READ    = 8'h00;

    // -----------------------------------------------------------------
    // widths and filter figures
    // -----------------------------------------------------------------
    localparam int AXES     = 3;
    localparam int SAMPLE_W = 16;
    localparam int COEFF_W  = 13;
    localparam int RATE_W   = 12;
    localparam int CUTOFF_W = 21;
    localparam logic [COEFF_W-1:0] HP_COEFF_512  = 13'h0200;
    localparam logic [COEFF_W-1:0] HP_COEFF_1024 = 13'h0400;
    localparam logic [COEFF_W-1:0] HP_COEFF_2048 = 13'h0800;
    localparam logic [COEFF_W-1:0] HP_COEFF_4096 = 13'h1000;
    localparam logic [3:0]         HP_SHIFT_BASE = 4'h9;
    // 0.318 in thousandths, cut-off result is in millihertz
    localparam logic [8:0]         CUTOFF_MILLI  = 9'h13e;

    // external clock figures the far side must meet
    localparam int EXT_CLK_KHZ     = 1045;
    localparam int EXT_CLK_TOL_PCT = 10;
    localparam int EXT_CLK_DUTY    = 50;

    // -----------------------------------------------------------------
    // carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [SAMPLE_W-1:0] z;
        logic [SAMPLE_W-1:0] y;
        logic [SAMPLE_W-1:0] x;
    } axis_triplet_type;

    typedef struct packed {
        logic       ext_clock_sel;
        logic       dir_detect_filter_en;
        logic       freefall_filter_en;
        logic       filtered_out_sel;
        logic [1:0] reserved;
        logic [1:0] cutoff_coeff_sel;
    } control_fields_type;

    typedef struct packed {
        logic set_overrun;
        logic z_overrun;
        logic y_overrun;
        logic x_overrun;
        logic set_available;
        logic z_new_flag;
        logic y_new_flag;
        logic x_new_flag;
    } status_fields_type;

    // cut-off field to high-pass coefficient
    function automatic logic [COEFF_W-1:0] hp_coeff_lookup(
        input logic [1:0] sel
    );
        unique case (sel)
            2'h0: hp_coeff_lookup = HP_COEFF_512;
            2'h1: hp_coeff_lookup = HP_COEFF_1024;
            2'h2: hp_coeff_lookup = HP_COEFF_2048;
            2'h3: hp_coeff_lookup = HP_COEFF_4096;
        endcase
    endfunction : hp_coeff_lookup

endpackage : accel_filter_pkg

// ==== design/axis_sample_flags.sv ====
// new-sample and overrun flags of one axis
`timescale 1ns/1ps
module axis_sample_flags (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // events
    input  wire logic new_sample,
    input  wire logic high_read,
    // flags
    output logic      new_flag_q,
    output logic      overrun_q
);

    logic new_flag_d;
    logic overrun_d;

    // next flag values, a new sample wins over a read for the new flag, a read wins for overrun
    always_comb begin
        // [R14] set on new sample
        // [R17] cleared by high read
        if (new_sample) begin
            new_flag_d = 1'b1;
        end else if (high_read) begin
            new_flag_d = 1'b0;
        end else begin
            new_flag_d = new_flag_q;
        end
        // [R13] unread sample overwritten
        // [R18] cleared by high read
        if (new_sample && new_flag_q && !high_read) begin
            overrun_d = 1'b1;
        end else if (high_read) begin
            overrun_d = 1'b0;
        end else begin
            overrun_d = overrun_q;
        end
    end

    // flag registers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            new_flag_q <= 1'b0;
            overrun_q  <= 1'b0;
        end else begin
            new_flag_q <= new_flag_d;
            overrun_q  <= overrun_d;
        end
    end

endmodule : axis_sample_flags

// ==== design/accel_filter_path_and_status.sv ====
// control, identification and status registers of the filter path
`timescale 1ns/1ps
module accel_filter_path_and_status #(
    parameter logic [7:0] ID_VALUE = 8'h5c  // arbitrary identifier value
) (
    // clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        reset_n,
    // register port from the serial interface
    input  wire logic [6:0]                  reg_addr,
    input  wire logic                        reg_wr_stb,
    input  wire logic                        reg_rd_stb,
    input  wire logic [7:0]                  reg_wr_data,
    output logic      [7:0]                  reg_rd_data_q,
    output logic                             reg_rd_valid_q,
    // sample sources
    input  accel_filter_pkg::axis_triplet_type raw_sample,
    input  accel_filter_pkg::axis_triplet_type hp_sample,
    input  wire logic [2:0]                  new_sample,
    input  wire logic [2:0]                  axis_en,
    input  wire logic [2:0]                  high_byte_read,
    input  wire logic [11:0]                 output_data_rate,
    // interrupt generator results
    input  wire logic [7:0]                  ig_fall_wake_result,
    input  wire logic                        ig_fall_wake_load,
    input  wire logic [7:0]                  ig_direction_result,
    input  wire logic                        ig_direction_load,
    // selected data paths
    output accel_filter_pkg::axis_triplet_type out_reg_sample_q,
    output accel_filter_pkg::axis_triplet_type dir_detect_sample_q,
    output accel_filter_pkg::axis_triplet_type fall_wake_sample_q,
    // filter settings
    output logic      [12:0]                 hp_coeff_q,
    output logic      [3:0]                  hp_shift_q,
    output logic      [20:0]                 cutoff_mhz_q,
    // clock source control
    output logic                             ext_clock_sel_q,
    output logic                             int_osc_en_q,
    output logic                             ext_osc_pin_pulldown_en_q,
    // source registers
    output logic      [7:0]                  fall_wake_source_q,
    output logic      [7:0]                  direction_source_q
);

    // -----------------------------------------------------------------
    // control register
    // -----------------------------------------------------------------
    accel_filter_pkg::control_fields_type control_q;
    accel_filter_pkg::control_fields_type control_d;

    // write decode, reserved pair always kept at default
    always_comb begin
        control_d = control_q;
        if (reg_wr_stb &&
            reg_addr == accel_filter_pkg::ADDR_FILTER_CLOCK_CONTROL) begin
            // [R3] field layout on write
            control_d          = reg_wr_data;
            control_d.reserved = accel_filter_pkg::RESERVED_DEFAULT;
        end
    end

    // control register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            // [R3] fields reset zero
            control_q <= accel_filter_pkg::CONTROL_RESET;
        end else begin
            control_q <= control_d;
        end
    end

    // -----------------------------------------------------------------
    // data path selection and filter settings
    // -----------------------------------------------------------------
    accel_filter_pkg::axis_triplet_type out_reg_sample_d;
    accel_filter_pkg::axis_triplet_type dir_detect_sample_d;
    accel_filter_pkg::axis_triplet_type fall_wake_sample_d;
    logic [12:0] hp_coeff_d;
    logic [3:0]  hp_shift_d;
    logic [20:0] cutoff_prod;
    logic [20:0] cutoff_mhz_d;
    logic        ext_clock_sel_d;
    logic [7:0]  fall_wake_source_d;
    logic [7:0]  direction_source_d;

    // path muxes, coefficient and cut-off
    always_comb begin
        // [R6] output register source
        out_reg_sample_d = control_q.filtered_out_sel ? hp_sample
                                                      : raw_sample;
        // [R4] direction detect source
        dir_detect_sample_d = control_q.dir_detect_filter_en ? hp_sample
                                                             : raw_sample;
        // [R5] free-fall source
        fall_wake_sample_d = control_q.freefall_filter_en ? hp_sample
                                                          : raw_sample;
        // [R7] coefficient decode
        hp_coeff_d = accel_filter_pkg::hp_coeff_lookup(
                         control_q.cutoff_coeff_sel);
        hp_shift_d = accel_filter_pkg::HP_SHIFT_BASE +
                     {2'h0, control_q.cutoff_coeff_sel};
        // [R8] cut-off is 0.318 over coefficient times half rate
        cutoff_prod  = 21'(output_data_rate) *
                       21'(accel_filter_pkg::CUTOFF_MILLI);
        cutoff_mhz_d = cutoff_prod >> (hp_shift_d + 4'h1);
        // [R1] clock source select
        ext_clock_sel_d = control_q.ext_clock_sel;
        // [R9] generator results into source registers
        fall_wake_source_d = ig_fall_wake_load ? ig_fall_wake_result
                                               : fall_wake_source_q;
        direction_source_d = ig_direction_load ? ig_direction_result
                                               : direction_source_q;
    end

    // path and setting registers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_reg_sample_q          <= '0;
            dir_detect_sample_q       <= '0;
            fall_wake_sample_q        <= '0;
            hp_coeff_q                <= accel_filter_pkg::HP_COEFF_512;
            hp_shift_q                <= accel_filter_pkg::HP_SHIFT_BASE;
            cutoff_mhz_q              <= '0;
            ext_clock_sel_q           <= 1'b0;
            int_osc_en_q              <= 1'b1;
            ext_osc_pin_pulldown_en_q <= 1'b1;
            fall_wake_source_q        <= 8'h00;
            direction_source_q        <= 8'h00;
        end else begin
            out_reg_sample_q          <= out_reg_sample_d;
            dir_detect_sample_q       <= dir_detect_sample_d;
            fall_wake_sample_q        <= fall_wake_sample_d;
            hp_coeff_q                <= hp_coeff_d;
            hp_shift_q                <= hp_shift_d;
            cutoff_mhz_q              <= cutoff_mhz_d;
            ext_clock_sel_q           <= ext_clock_sel_d;
            // [R1] oscillator off and pull-down off on external clock
            int_osc_en_q              <= !ext_clock_sel_d;
            ext_osc_pin_pulldown_en_q <= !ext_clock_sel_d;
            fall_wake_source_q        <= fall_wake_source_d;
            direction_source_q        <= direction_source_d;
        end
    end

    // -----------------------------------------------------------------
    // per-axis flags
    // -----------------------------------------------------------------
    logic [2:0] new_gated;
    logic [2:0] read_gated;
    logic [2:0] axis_new_q;
    logic [2:0] axis_over_q;

    assign new_gated  = new_sample & axis_en;
    assign read_gated = high_byte_read & axis_en;

    // one flag pair per axis
    for (genvar a = 0; a < accel_filter_pkg::AXES; a++) begin : g_axis
        axis_sample_flags u_flags (
            .core_clk   (core_clk),
            .reset_n    (reset_n),
            .new_sample (new_gated[a]),
            .high_read  (high_byte_read[a]),
            .new_flag_q (axis_new_q[a]),
            .overrun_q  (axis_over_q[a])
        );
    end

    // -----------------------------------------------------------------
    // whole-set flags
    // -----------------------------------------------------------------
    logic [2:0] got_q;
    logic [2:0] got_d;
    logic [2:0] read_q;
    logic [2:0] read_d;
    logic [2:0] got_acc;
    logic [2:0] read_acc;
    logic       set_event;
    logic       read_done;
    logic       set_available_q;
    logic       set_available_d;
    logic       set_overrun_q;
    logic       set_overrun_d;

    // collect new samples and high reads of the enabled axes
    always_comb begin
        got_acc   = got_q | new_gated;
        read_acc  = read_q | read_gated;
        set_event = (axis_en != 3'h0) && ((got_acc & axis_en) == axis_en);
        read_done = (axis_en != 3'h0) && ((read_acc & axis_en) == axis_en);
        got_d     = set_event ? 3'h0 : got_acc;
        read_d    = (set_event || read_done) ? 3'h0 : read_acc;
        // [R15] set on full set, cleared after reads
        if (set_event) begin
            set_available_d = 1'b1;
        end else if (read_done) begin
            set_available_d = 1'b0;
        end else begin
            set_available_d = set_available_q;
        end
        // [R12] unread set overwritten
        // [R16] cleared after all high reads
        if (set_event && set_available_q && !read_done) begin
            set_overrun_d = 1'b1;
        end else if (read_done) begin
            set_overrun_d = 1'b0;
        end else begin
            set_overrun_d = set_overrun_q;
        end
    end

    // whole-set registers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            got_q           <= 3'h0;
            read_q          <= 3'h0;
            set_available_q <= 1'b0;
            set_overrun_q   <= 1'b0;
        end else begin
            got_q           <= got_d;
            read_q          <= read_d;
            set_available_q <= set_available_d;
            set_overrun_q   <= set_overrun_d;
        end
    end

    // -----------------------------------------------------------------
    // read port
    // -----------------------------------------------------------------
    accel_filter_pkg::status_fields_type status_view;
    logic [7:0] reg_rd_data_d;

    // [R11] status flag layout
    always_comb begin
        status_view.set_overrun   = set_overrun_q;
        status_view.z_overrun     = axis_over_q[2];
        status_view.y_overrun     = axis_over_q[1];
        status_view.x_overrun     = axis_over_q[0];
        status_view.set_available = set_available_q;
        status_view.z_new_flag    = axis_new_q[2];
        status_view.y_new_flag    = axis_new_q[1];
        status_view.x_new_flag    = axis_new_q[0];
    end

    // read decode; [R20] writes to status and id hit no storage
    always_comb begin
        reg_rd_data_d = reg_rd_data_q;
        if (reg_rd_stb) begin
            unique case (reg_addr)
                // [R10] fixed identifier
                accel_filter_pkg::ADDR_ID_CODE:
                    reg_rd_data_d = ID_VALUE;
                accel_filter_pkg::ADDR_FILTER_CLOCK_CONTROL:
                    reg_rd_data_d = control_q;
                accel_filter_pkg::ADDR_SAMPLE_STATUS:
                    reg_rd_data_d = status_view;
                default:
                    reg_rd_data_d = accel_filter_pkg::UNMAPPED_READ;
            endcase
        end
    end

    // read data registers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rd_data_q  <= 8'h00;
            reg_rd_valid_q <= 1'b0;
        end else begin
            reg_rd_data_q  <= reg_rd_data_d;
            reg_rd_valid_q <= reg_rd_stb;
        end
    end

endmodule : accel_filter_path_and_status

// ==== test/accel_filter_sva.sv ====
// assertion checker for the filter path and status bank
`timescale 1ns/1ps
module accel_filter_sva #(
    parameter logic [7:0] ID_VALUE = 8'h5c  // arbitrary identifier value
) (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       reset_n,
    // register port
    input wire logic [6:0] reg_addr,
    input wire logic       reg_wr_stb,
    input wire logic       reg_rd_stb,
    input wire logic [7:0] reg_wr_data,
    input wire logic [7:0] reg_rd_data_q,
    input wire logic       reg_rd_valid_q,
    // data paths
    input accel_filter_pkg::axis_triplet_type raw_sample,
    input accel_filter_pkg::axis_triplet_type hp_sample,
    input accel_filter_pkg::axis_triplet_type out_reg_sample_q,
    input accel_filter_pkg::axis_triplet_type dir_detect_sample_q,
    input accel_filter_pkg::axis_triplet_type fall_wake_sample_q,
    // settings
    input wire logic [12:0] hp_coeff_q,
    input wire logic [3:0]  hp_shift_q,
    input wire logic        ext_clock_sel_q,
    input wire logic        int_osc_en_q,
    input wire logic        ext_osc_pin_pulldown_en_q,
    // source registers
    input wire logic [7:0]  ig_fall_wake_result,
    input wire logic        ig_fall_wake_load,
    input wire logic [7:0]  ig_direction_result,
    input wire logic        ig_direction_load,
    input wire logic [7:0]  fall_wake_source_q,
    input wire logic [7:0]  direction_source_q
);
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic       live_q;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // mirror of the control register from host writes
    always_comb begin
        ctl_d = ctl_q;
        if (reg_wr_stb && reg_addr == 7'h22) begin
            ctl_d = reg_wr_data;
        end
    end

    // live marks that the previous edge was out of reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_q  <= 8'h08;
            live_q <= 1'b0;
        end else begin
            ctl_q  <= ctl_d;
            live_q <= 1'b1;
        end
    end

    property p_clock_source;
        live_q |-> ext_clock_sel_q == $past(ctl_q[7])
            && int_osc_en_q == !ext_clock_sel_q
            && ext_osc_pin_pulldown_en_q == !ext_clock_sel_q;
    endproperty
    a_clock_source: assert property (p_clock_source)
        else $error("clock source outputs disagree with select");

    property p_ctl_readback;
        reg_rd_stb && reg_addr == 7'h22 |=> reg_rd_valid_q
            && reg_rd_data_q == {$past(ctl_q[7:4]), 2'h2, $past(ctl_q[1:0])};
    endproperty
    a_ctl_readback: assert property (p_ctl_readback)
        else $error("control read back wrong");

    property p_dir_path;
        live_q |-> dir_detect_sample_q == ($past(ctl_q[6]) ?
            $past(hp_sample) : $past(raw_sample));
    endproperty
    a_dir_path: assert property (p_dir_path)
        else $error("direction path source wrong");

    property p_fall_path;
        live_q |-> fall_wake_sample_q == ($past(ctl_q[5]) ?
            $past(hp_sample) : $past(raw_sample));
    endproperty
    a_fall_path: assert property (p_fall_path)
        else $error("free-fall path source wrong");

    property p_out_path;
        live_q |-> out_reg_sample_q == ($past(ctl_q[4]) ?
            $past(hp_sample) : $past(raw_sample));
    endproperty
    a_out_path: assert property (p_out_path)
        else $error("output register source wrong");

    property p_coeff;
        live_q |-> hp_coeff_q == (13'h0200 << $past(ctl_q[1:0]))
            && hp_shift_q == 4'h9 + {2'h0, $past(ctl_q[1:0])};
    endproperty
    a_coeff: assert property (p_coeff)
        else $error("coefficient does not follow cut-off field");

    property p_fall_source;
        ig_fall_wake_load |=>
            fall_wake_source_q == $past(ig_fall_wake_result);
    endproperty
    a_fall_source: assert property (p_fall_source)
        else $error("fall/wake source not loaded");

    property p_dir_source;
        ig_direction_load |=>
            direction_source_q == $past(ig_direction_result);
    endproperty
    a_dir_source: assert property (p_dir_source)
        else $error("direction source not loaded");

    property p_id_read;
        reg_rd_stb && reg_addr == 7'h0f |=>
            reg_rd_valid_q && reg_rd_data_q == ID_VALUE;
    endproperty
    a_id_read: assert property (p_id_read)
        else $error("identifier read wrong");
endmodule : accel_filter_sva

bind accel_filter_path_and_status accel_filter_sva #(
    .ID_VALUE(ID_VALUE)
) i_sva (
    .core_clk, .reset_n, .reg_addr, .reg_wr_stb, .reg_rd_stb,
    .reg_wr_data, .reg_rd_data_q, .reg_rd_valid_q, .raw_sample,
    .hp_sample, .out_reg_sample_q, .dir_detect_sample_q,
    .fall_wake_sample_q, .hp_coeff_q, .hp_shift_q, .ext_clock_sel_q,
    .int_osc_en_q, .ext_osc_pin_pulldown_en_q, .ig_fall_wake_result,
    .ig_fall_wake_load, .ig_direction_result, .ig_direction_load,
    .fall_wake_source_q, .direction_source_q
);

// ==== test/sample_source_model.sv ====
// sample source model: raw and filtered triplets changing every cycle
`timescale 1ns/1ps
module sample_source_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // sample triplets
    output accel_filter_pkg::axis_triplet_type raw_sample,
    output accel_filter_pkg::axis_triplet_type hp_sample
);
    logic [15:0] count_q;

    // free-running count so a stale mux shows at once
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= 16'h0000;
        end else begin
            count_q <= count_q + 16'h0001;
        end
    end

    // raw and filtered never equal
    assign raw_sample = {count_q, count_q ^ 16'h00ff, count_q ^ 16'h0f0f};
    assign hp_sample  = {~count_q, count_q ^ 16'hff00, count_q ^ 16'hf0f0};
endmodule : sample_source_model

// ==== test/accel_filter_path_and_status_tb_top.sv ====
// self-checking testbench for the filter path and status bank
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("[FAIL] %0t got %h want %h", $time, got, exp); \
        end \
    end
module accel_filter_path_and_status_tb_top;
    localparam logic [7:0] ID_VALUE = 8'h5c;  // arbitrary identifier value
    logic        core_clk, reset_n, reg_wr_stb, reg_rd_stb, reg_rd_valid_q;
    logic [6:0]  reg_addr;
    logic [7:0]  reg_wr_data, reg_rd_data_q, ig_fall_wake_result;
    logic [7:0]  ig_direction_result, fall_wake_source_q, direction_source_q;
    logic        ig_fall_wake_load, ig_direction_load, ext_clock_sel_q;
    logic        int_osc_en_q, ext_osc_pin_pulldown_en_q;
    logic [2:0]  new_sample, axis_en, high_byte_read;
    logic [11:0] output_data_rate;
    logic [12:0] hp_coeff_q;
    logic [3:0]  hp_shift_q;
    logic [20:0] cutoff_mhz_q;
    accel_filter_pkg::axis_triplet_type raw_sample, hp_sample;
    accel_filter_pkg::axis_triplet_type out_reg_sample_q;
    accel_filter_pkg::axis_triplet_type dir_detect_sample_q;
    accel_filter_pkg::axis_triplet_type fall_wake_sample_q;
    logic [7:0]  cfg [5] = '{8'h88, 8'h48, 8'h28, 8'h18, 8'h08};
    int          n_mismatch = 0;
    int          checks_done = 0;

    sample_source_model i_src (.core_clk, .reset_n, .raw_sample, .hp_sample);

    accel_filter_path_and_status #(.ID_VALUE(ID_VALUE)) i_dut (
        .core_clk, .reset_n, .reg_addr, .reg_wr_stb, .reg_rd_stb,
        .reg_wr_data, .reg_rd_data_q, .reg_rd_valid_q, .raw_sample,
        .hp_sample, .new_sample, .axis_en, .high_byte_read,
        .output_data_rate, .ig_fall_wake_result, .ig_fall_wake_load,
        .ig_direction_result, .ig_direction_load, .out_reg_sample_q,
        .dir_detect_sample_q, .fall_wake_sample_q, .hp_coeff_q,
        .hp_shift_q, .cutoff_mhz_q, .ext_clock_sel_q, .int_osc_en_q,
        .ext_osc_pin_pulldown_en_q, .fall_wake_source_q,
        .direction_source_q
    );

    // ---------------------------------------------------------------
    // register port and event tasks
    // ---------------------------------------------------------------
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr    <= a;
        reg_wr_data <= d;
        reg_wr_stb  <= 1'b1;
        @(posedge core_clk);
        reg_wr_stb  <= 1'b0;
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr   <= a;
        reg_rd_stb <= 1'b1;
        @(posedge core_clk);
        reg_rd_stb <= 1'b0;
        #1;
        `CHK(reg_rd_valid_q, 1'b1)
        `CHK(reg_rd_data_q, e)
    endtask : rd

    task automatic ev(input logic [2:0] ns, input logic [2:0] hb);
        @(posedge core_clk);
        new_sample     <= ns;
        high_byte_read <= hb;
        @(posedge core_clk);
        new_sample     <= 3'h0;
        high_byte_read <= 3'h0;
    endtask : ev

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    // clock and watchdog
    // even duty clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #200000;
        n_mismatch++;
        stop_test();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        {reset_n, reg_wr_stb, reg_rd_stb, reg_addr, reg_wr_data} = '0;
        {new_sample, high_byte_read, ig_fall_wake_load} = '0;
        {ig_direction_load, ig_fall_wake_result, ig_direction_result} = '0;
        axis_en          = 3'h7;
        output_data_rate = 12'd1000;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        #1;
        `CHK(ext_osc_pin_pulldown_en_q, 1'b1)
        rd(7'h22, 8'h08);
        rd(7'h27, 8'h00);
        rd(7'h0f, ID_VALUE);
        rd(7'h30, 8'h00);
        $display("reset test done");
        for (int c = 0; c < 4; c++) begin
            wr(7'h22, 8'h08 | 8'(c));
            rd(7'h22, 8'h08 | 8'(c));
            `CHK(hp_coeff_q, 13'h0200 << c)
            `CHK(cutoff_mhz_q, 21'((32'd1000 * 32'd318) >> (c + 10)))
        end
        foreach (cfg[i]) begin
            wr(7'h22, cfg[i]);
            rd(7'h22, cfg[i]);
            `CHK(ext_clock_sel_q, cfg[i][7])
            `CHK(int_osc_en_q, ~cfg[i][7])
            `CHK(ext_osc_pin_pulldown_en_q, ~cfg[i][7])
        end
        $display("control test done");
        ev(3'h7, 3'h0);
        rd(7'h27, 8'h0f);
        ev(3'h7, 3'h0);
        rd(7'h27, 8'hff);
        ev(3'h0, 3'h1);
        rd(7'h27, 8'hee);
        ev(3'h0, 3'h6);
        rd(7'h27, 8'h00);
        axis_en <= 3'h3;
        ev(3'h3, 3'h0);
        ev(3'h4, 3'h0);
        rd(7'h27, 8'h0b);
        ev(3'h0, 3'h3);
        rd(7'h27, 8'h00);
        wr(7'h27, 8'hff);
        rd(7'h27, 8'h00);
        wr(7'h0f, 8'h00);
        rd(7'h0f, ID_VALUE);
        $display("status test done");
        @(posedge core_clk);
        ig_fall_wake_result <= 8'h5a;
        ig_fall_wake_load   <= 1'b1;
        ig_direction_result <= 8'ha5;
        ig_direction_load   <= 1'b1;
        @(posedge core_clk);
        ig_fall_wake_load   <= 1'b0;
        ig_direction_load   <= 1'b0;
        #1;
        `CHK(fall_wake_source_q, 8'h5a)
        `CHK(direction_source_q, 8'ha5)
        $display("source test done");
        stop_test();
    end
endmodule : accel_filter_path_and_status_tb_top
